// file: testbench/pfl_loop_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pfl_loop_ctrl_chk (
	input wire logic               clk,
	input wire logic               arst_n,
	input wire logic               pll_enable,
	input wire logic               pll_lock_raw,
	input wire logic               pll_lock_lost_clr,
	input wire logic [1:0]         pll_bypass_sel,
	input wire logic               pll_locked,
	input wire logic               pll_lock_lost,
	input wire logic               pll_out_sel_loop,
	input wire logic               fll_enable,
	input wire logic               osc_ready_flag,
	input wire logic               fll_busy,
	input wire logic               fll_locked,
	input wire logic signed [18:0] fll_error,
	input wire logic [11:0]        error_tolerance,
	input wire logic [8:0]         osc_trim_code,
	input wire logic [8:0]         osc_trim_init
);
	// mirrors the two-flop release so the first edges are not judged
	logic [1:0]  up_r;
	logic [18:0] e_abs;
	logic [11:0] tol_eff;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			up_r <= 2'h0;
		else
			up_r <= {up_r[0], 1'b1};
	end
	assign e_abs = fll_error[18] ? 19'(-fll_error) : fll_error;
	assign tol_eff = (error_tolerance == 12'h000) ? 12'h001 : error_tolerance;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!up_r[1]);
	sequence s_drop;
		pll_locked && pll_enable && !pll_lock_raw;
	endsequence
	chk_lock_follow: assert property (pll_enable && pll_lock_raw |=> pll_locked)
		else $error("pll lock not reported");
	chk_lost_set: assert property (s_drop |=> pll_lock_lost)
		else $error("lock loss not flagged");
	chk_lost_hold: assert property (pll_lock_lost && !pll_lock_lost_clr |=> pll_lock_lost)
		else $error("lock loss flag dropped");
	chk_auto_sel: assert property (!pll_bypass_sel[1] |=> pll_out_sel_loop == pll_locked)
		else $error("auto output select wrong");
	chk_idle_unlock: assert property (!fll_enable |=> !fll_locked)
		else $error("fll lock while disabled");
	chk_idle_trim: assert property (!fll_enable && !fll_busy |=> osc_trim_code == $past(osc_trim_init))
		else $error("idle trim not start value");
	chk_run_start: assert property (fll_enable && osc_ready_flag && !fll_busy |-> ##[1:2] fll_busy)
		else $error("fll did not start");
	chk_error_tolerance: assert property ($rose(fll_locked) |-> e_abs <= 19'(tol_eff))
		else $error("fll lock outside tolerance");
endmodule
bind pfl_loop_ctrl pfl_loop_ctrl_chk u_chk (.clk, .arst_n, .pll_enable, .pll_lock_raw,
	.pll_lock_lost_clr, .pll_bypass_sel, .pll_locked, .pll_lock_lost, .pll_out_sel_loop,
	.fll_enable, .osc_ready_flag, .fll_busy, .fll_locked, .fll_error, .error_tolerance,
	.osc_trim_code, .osc_trim_init);
`default_nettype wire

// file: testbench/pfl_loop_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pfl_loop_ctrl_tb_top;
	logic        clk = 1'b0, arst_n = 1'b0;
	logic        pll_enable = 1'b0, pll_lock_raw = 1'b0, pll_lock_lost_clr = 1'b0;
	logic [4:0]  pll_ref_div = 5'h00, pll_out_div = 5'h00;
	logic [6:0]  pll_fb_div = 7'h00;
	logic [1:0]  pll_bypass_sel = 2'h0;
	logic        fll_enable = 1'b0, osc_power_on = 1'b0;
	logic [12:0] fll_window_length = 13'h0002, settle_count = 13'h0001;
	logic [17:0] fll_target_count = 18'h00000;
	logic [3:0]  integral_gain_code = 4'h0, proportional_gain_code = 4'h0;
	logic [8:0]  trim_step_limit = 9'h1FF, osc_trim_init = 9'h100;
	logic [11:0] error_tolerance = 12'h000;
	logic [2:0]  osc_band_select = 3'h2, k = 3'h3;
	logic        ref_tick, osc_tick, osc_ready_flag;
	logic        pll_enable_out, pll_out_sel_loop, pll_locked, pll_lock_lost;
	logic [4:0]  pll_ref_div_out, pll_out_div_out;
	logic [6:0]  pll_fb_div_out;
	logic [8:0]  osc_trim_code;
	logic [2:0]  osc_band_out;
	logic        osc_power_out, fll_locked, fll_busy;
	logic signed [18:0] fll_error;
	int          err_total = 0, num_checks = 0;
	pfl_loop_ctrl dut (.clk, .arst_n, .pll_enable, .pll_ref_div, .pll_fb_div, .pll_out_div,
		.pll_bypass_sel, .pll_lock_raw, .pll_lock_lost_clr, .pll_enable_out, .pll_ref_div_out,
		.pll_fb_div_out, .pll_out_div_out, .pll_out_sel_loop, .pll_locked, .pll_lock_lost,
		.fll_enable, .ref_tick, .osc_tick, .fll_window_length, .fll_target_count,
		.integral_gain_code, .proportional_gain_code, .trim_step_limit, .error_tolerance,
		.settle_count, .osc_trim_init, .osc_band_select, .osc_power_on, .osc_ready_flag,
		.osc_trim_code, .osc_band_out, .osc_power_out, .fll_error, .fll_locked, .fll_busy);
	pfl_osc_model osc (.clk, .power(osc_power_out), .per_ref(k), .ref_tick, .osc_tick,
		.ready(osc_ready_flag));
	always #12.5 clk = ~clk;
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input string n, input logic [18:0] e, input logic [18:0] s);
		num_checks++;
		if (e !== s) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic pll_seq();
		pll_ref_div = 5'h02;
		pll_fb_div = 7'h30;
		pll_out_div = 5'h04;
		step(1);
		pll_enable = 1'b1;
		step(40);
		chk("en_out", 19'h1, pll_enable_out);
		chk("pre_lock", 19'h0, pll_out_sel_loop);
		pll_lock_raw = 1'b1;
		step(1);
		chk("ref_div", 19'h2, pll_ref_div_out);
		chk("out_div", 19'h4, pll_out_div_out);
		chk("locked", 19'h1, pll_locked);
		chk("auto_sel", 19'h1, pll_out_sel_loop);
		// divider change while running must be ignored
		pll_fb_div = 7'h11;
		pll_lock_raw = 1'b0;
		step(1);
		chk("fb_hold", 19'h30, pll_fb_div_out);
		chk("unlock_sel", 19'h0, pll_out_sel_loop);
		pll_lock_raw = 1'b1;
		pll_bypass_sel = 2'h1;
		step(1);
		chk("auto_b_sel", 19'h1, pll_out_sel_loop);
		chk("lost", 19'h1, pll_lock_lost);
		chk("relock", 19'h1, pll_locked);
		pll_lock_lost_clr = 1'b1;
		step(1);
		pll_lock_lost_clr = 1'b0;
		chk("lost_clr", 19'h0, pll_lock_lost);
		pll_bypass_sel = 2'h2;
		step(1);
		chk("force_ref", 19'h0, pll_out_sel_loop);
		step(6);
		pll_enable = 1'b0;
		pll_bypass_sel = 2'h3;
		step(1);
		chk("off", 19'h0, pll_locked);
		chk("force_loop", 19'h1, pll_out_sel_loop);
	endtask
	task automatic fll_case(input logic [2:0] kk, input logic [17:0] tgt, input logic [3:0] gi,
		input logic [3:0] gp, input logic [8:0] lim, input logic [8:0] ini, input int e,
		input int d, input logic lk);
		int nt;
		k = kk;
		fll_target_count = tgt;
		integral_gain_code = gi;
		proportional_gain_code = gp;
		trim_step_limit = lim;
		osc_trim_init = ini;
		error_tolerance = {11'h000, !lk};
		step(2);
		fll_enable = 1'b1;
		// first window starts off the reference phase, so only the second is judged
		for (int i = 0; i < 200 && osc_trim_code === ini; i++)
			step(1);
		num_checks++;
		if (osc_trim_code === ini) begin
			err_total++;
			$display("BAD trim_move expected change seen %h", osc_trim_code);
		end
		nt = osc_trim_code + d;
		nt = nt > 511 ? 511 : (nt < 0 ? 0 : nt);
		repeat (3) @(posedge ref_tick);
		step(4);
		chk("error", 19'(e), fll_error);
		chk("trim", 19'(nt), osc_trim_code);
		chk("flock", 19'(lk), fll_locked);
		fll_enable = 1'b0;
		step(2);
		chk("idle_lock", 19'h0, fll_locked);
		chk("idle_trim", 19'(ini), osc_trim_code);
	endtask
	initial begin
		step(10);
		arst_n = 1'b1;
		step(3);
		pll_seq();
		osc_power_on = 1'b1;
		for (int i = 0; i < 50 && osc_ready_flag !== 1'b1; i++)
			step(1);
		chk("ready", 19'h1, osc_ready_flag);
		chk("band", 19'h2, osc_band_out);
		chk("power", 19'h1, osc_power_out);
		fll_case(3'h3, 18'h00004, 4'h9, 4'h7, 9'h1FF, 9'h100, 2, 5, 1'b0);
		fll_case(3'h3, 18'h00007, 4'h0, 4'h9, 9'h1FF, 9'h100, -1, -3, 1'b1);
		fll_case(3'h3, 18'h00004, 4'hB, 4'hB, 9'h003, 9'h100, 2, 3, 1'b0);
		fll_case(3'h3, 18'h00007, 4'hB, 4'hB, 9'h1FF, 9'h002, -1, -16, 1'b1);
		fll_case(3'h6, 18'h00004, 4'hA, 4'hB, 9'h1FF, 9'h1F0, 8, 96, 1'b0);
		test_done();
	end
	initial begin
		#100000;
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire

// file: testbench/pfl_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfl_osc_model (
	input  wire logic       clk,
	input  wire logic       power,
	input  wire logic [2:0] per_ref,
	output logic            ref_tick = 1'b0,
	output logic            osc_tick = 1'b0,
	output logic            ready = 1'b0
);
	logic [2:0] ph_r = 3'h0;
	logic [2:0] rdy_r = 3'h0;
	// ticks stand for the halved oscillator output, the undivided mode is never modelled
	// osc pulses kept off the first phase so window start alignment cannot shift the count
	always @(negedge clk) begin
		ph_r <= ph_r + 3'h1;
		ref_tick <= (ph_r == 3'h7);
		osc_tick <= (ph_r != 3'h7) && (ph_r != 3'h0) && (ph_r <= per_ref);
		rdy_r <= power ? {rdy_r[1:0], 1'b1} : 3'h0;
		ready <= rdy_r[2];
	end
endmodule
`default_nettype wire

// file: verilog/pfl_defines.svh
`ifndef PFL_DEFINES_SVH
`define PFL_DEFINES_SVH

// field widths
`define PFL_PLL_REF_W   5
`define PFL_PLL_FB_W    7
`define PFL_PLL_OUT_W   5
`define PFL_WIN_W       13
`define PFL_CNT_W       18
`define PFL_ERR_W       19
`define PFL_TOL_W       12
`define PFL_SETTLE_W    13
`define PFL_TRIM_W      9
`define PFL_BAND_W      3
`define PFL_GAIN_W      4
`define PFL_SCALE_W     32

// bypass select encodings
`define PFL_BYP_AUTO    2'h0
`define PFL_BYP_AUTO_B  2'h1
`define PFL_BYP_REF     2'h2
`define PFL_BYP_LOOP    2'h3

// gain code 0..11 means 2^(code-8)
`define PFL_GAIN_MAX    4'hB
`define PFL_GAIN_FRAC   8

`define PFL_TRIM_MAX    9'h1FF
`define PFL_TRIM_RST    9'h100
`define PFL_CNT_MAX     18'h3FFFF
`define PFL_TOL_MIN     12'h001

`endif

// file: verilog/pfl_loop_ctrl.sv
// Functional notes
// R1: software keeps phase detector 4-8 MHz, VCO 170-400 MHz, output 10.625-200 MHz.
// R2: output equals reference over ref divider, times feedback, over output divider.
// R3: software never enables in the divider-write cycle nor changes dividers while on.
// R4: software waits one microsecond after enable before trusting the loop.
// R5: output follows reference until lock, then loop; bypass select overrides this.
// R6: status shows locked now, and a separate sticky lock-lost bit.
// R7: disable by selecting reference, waiting six output cycles, then clearing enable.
// R8: FLL output 24-100 MHz, reference 0.001-100 MHz, oscillator at least 2.5x reference.
// R9: oscillator spans 48-200 MHz in five bands; software picks the band.
// R10: software always keeps the oscillator divide-by-two enabled.
// R11: a 9-bit trim code sets frequency in band, updated by hardware.
// R12: oscillator cycles are counted over window-length reference cycles.
// R13: error is measured count minus target count, signed.
// R14: error times summed gains is added to the trim code.
// R15: a limit field caps the trim adjustment magnitude.
// R16: lock is reported while error magnitude is within tolerance.
// R17: after each trim update wait settling-count reference cycles before measuring.
// R18: minimum tolerance is one, so error of plus or minus one stays locked.
// R19: gain codes 0 to 11 select 1/256 up to 8, doubling per step.
// R20: trim has 512 steps per band, updated from counter output.
// R21: software powers oscillator and waits for ready before continuing.
// R22: trim saturates at range ends and within limit, never wraps.
// R23: FLL lock updates per window and is low while disabled or before first window.
`timescale 1ns/1ps
`default_nettype none
`include "pfl_defines.svh"

module pfl_loop_ctrl (
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	// phase-locked loop control
	input  wire logic                          pll_enable,
	input  wire logic [`PFL_PLL_REF_W-1:0]     pll_ref_div,
	input  wire logic [`PFL_PLL_FB_W-1:0]      pll_fb_div,
	input  wire logic [`PFL_PLL_OUT_W-1:0]     pll_out_div,
	input  wire logic [1:0]                    pll_bypass_sel,
	input  wire logic                          pll_lock_raw,
	input  wire logic                          pll_lock_lost_clr,
	output logic                               pll_enable_out,
	output logic [`PFL_PLL_REF_W-1:0]          pll_ref_div_out,
	output logic [`PFL_PLL_FB_W-1:0]           pll_fb_div_out,
	output logic [`PFL_PLL_OUT_W-1:0]          pll_out_div_out,
	output logic                               pll_out_sel_loop,
	output logic                               pll_locked,
	output logic                               pll_lock_lost,
	// frequency-lock loop control
	input  wire logic                          fll_enable,
	input  wire logic                          ref_tick,
	input  wire logic                          osc_tick,
	input  wire logic [`PFL_WIN_W-1:0]         fll_window_length,
	input  wire logic [`PFL_CNT_W-1:0]         fll_target_count,
	input  wire logic [`PFL_GAIN_W-1:0]        integral_gain_code,
	input  wire logic [`PFL_GAIN_W-1:0]        proportional_gain_code,
	input  wire logic [`PFL_TRIM_W-1:0]        trim_step_limit,
	input  wire logic [`PFL_TOL_W-1:0]         error_tolerance,
	input  wire logic [`PFL_SETTLE_W-1:0]      settle_count,
	input  wire logic [`PFL_TRIM_W-1:0]        osc_trim_init,
	input  wire logic [`PFL_BAND_W-1:0]        osc_band_select,
	input  wire logic                          osc_power_on,
	input  wire logic                          osc_ready_flag,
	output logic [`PFL_TRIM_W-1:0]             osc_trim_code,
	output logic [`PFL_BAND_W-1:0]             osc_band_out,
	output logic                               osc_power_out,
	output logic signed [`PFL_ERR_W-1:0]       fll_error,
	output logic                               fll_locked,
	output logic                               fll_busy
);

	logic                        rst_meta_r;
	logic                        rst_n_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ---------------- phase-locked loop ----------------
	logic pll_locked_nxt;
	logic pll_sel_nxt;

	assign pll_locked_nxt = pll_enable && pll_lock_raw; // [R6]

	always_comb begin
		unique case (pll_bypass_sel)
			`PFL_BYP_REF:  pll_sel_nxt = 1'b0; // [R5]
			`PFL_BYP_LOOP: pll_sel_nxt = 1'b1; // [R5]
			default:       pll_sel_nxt = pll_locked_nxt; // [R5]
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pll_enable_out  <= 1'b0;
			pll_ref_div_out <= '0;
			pll_fb_div_out  <= '0;
			pll_out_div_out <= '0;
		end else begin
			pll_enable_out <= pll_enable;
			// dividers frozen while running, the analog side never sees a mid-lock change
			if (!pll_enable) begin // [R3]
				pll_ref_div_out <= pll_ref_div;
				pll_fb_div_out  <= pll_fb_div;
				pll_out_div_out <= pll_out_div;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pll_locked       <= 1'b0;
			pll_out_sel_loop <= 1'b0;
		end else begin
			pll_locked       <= pll_locked_nxt; // [R6]
			pll_out_sel_loop <= pll_sel_nxt; // [R5]
		end
	end

	// set wins over a clear in the same cycle; a plain disable is not a loss
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pll_lock_lost <= 1'b0;
		end else if (pll_locked && pll_enable && !pll_lock_raw) begin // [R6]
			pll_lock_lost <= 1'b1;
		end else if (pll_lock_lost_clr) begin
			pll_lock_lost <= 1'b0;
		end
	end

	// ---------------- frequency-lock loop ----------------
	pfl_pkg::pfl_fll_state_t      st_r;
	pfl_pkg::pfl_fll_state_t      st_nxt;
	logic [`PFL_WIN_W-1:0]        win_cnt_r;
	logic [`PFL_SETTLE_W-1:0]     settle_cnt_r;
	logic [`PFL_CNT_W-1:0]        osc_cnt_r;
	logic [`PFL_CNT_W-1:0]        osc_cnt_final;
	logic signed [`PFL_ERR_W-1:0] err_now;
	logic [`PFL_ERR_W-1:0]        err_mag;
	logic [`PFL_TOL_W-1:0]        tol_eff;
	logic [`PFL_TRIM_W-1:0]       trim_calc;
	logic                         win_done;
	logic                         settle_done;
	logic                         run;

	assign run = fll_enable && osc_ready_flag;
	// the last reference tick closes the window; include any oscillator edge on it
	assign win_done = ref_tick && (win_cnt_r + `PFL_WIN_W'(1) >= fll_window_length); // [R12]
	assign settle_done = (settle_count == '0) ||
		(ref_tick && (settle_cnt_r + `PFL_SETTLE_W'(1) >= settle_count)); // [R17]
	assign osc_cnt_final = (osc_tick && osc_cnt_r != `PFL_CNT_MAX) ?
		osc_cnt_r + `PFL_CNT_W'(1) : osc_cnt_r;
	assign err_now = $signed({1'b0, osc_cnt_final}) - $signed({1'b0, fll_target_count}); // [R13]
	assign err_mag = fll_error[`PFL_ERR_W-1] ? `PFL_ERR_W'(-fll_error) : `PFL_ERR_W'(fll_error);
	// zero tolerance would lock only on an exact count, so one count is the floor
	assign tol_eff = (error_tolerance < `PFL_TOL_MIN) ? `PFL_TOL_MIN : error_tolerance; // [R18]

	always_comb begin
		st_nxt = st_r;
		if (!run) begin
			st_nxt = pfl_pkg::PFL_IDLE;
		end else begin
			unique case (st_r)
				pfl_pkg::PFL_IDLE:    st_nxt = pfl_pkg::PFL_MEASURE;
				pfl_pkg::PFL_MEASURE: if (win_done) begin
					st_nxt = pfl_pkg::PFL_UPDATE;
				end
				pfl_pkg::PFL_UPDATE:  st_nxt = pfl_pkg::PFL_SETTLE;
				pfl_pkg::PFL_SETTLE:  if (settle_done) begin // [R17]
					st_nxt = pfl_pkg::PFL_MEASURE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= pfl_pkg::PFL_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// window and oscillator counters restart together at every measurement start
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			win_cnt_r <= '0;
			osc_cnt_r <= '0;
		end else if (st_r != pfl_pkg::PFL_MEASURE || win_done) begin
			win_cnt_r <= '0;
			osc_cnt_r <= '0;
		end else begin
			osc_cnt_r <= osc_cnt_final; // [R12]
			if (ref_tick) begin
				win_cnt_r <= win_cnt_r + `PFL_WIN_W'(1); // [R12]
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			settle_cnt_r <= '0;
		end else if (st_r != pfl_pkg::PFL_SETTLE) begin
			settle_cnt_r <= '0;
		end else if (ref_tick) begin
			settle_cnt_r <= settle_cnt_r + `PFL_SETTLE_W'(1); // [R17]
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			fll_error <= '0;
		end else if (st_r == pfl_pkg::PFL_MEASURE && win_done) begin
			fll_error <= err_now; // [R13]
		end
	end

	pfl_trim_calc u_trim_calc (
		.err      (fll_error),
		.igain    (integral_gain_code),
		.pgain    (proportional_gain_code),
		.limit    (trim_step_limit),
		.trim     (osc_trim_code),
		.trim_nxt (trim_calc)
	);

	// idle reloads the software start point so each enable begins from it
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			osc_trim_code <= `PFL_TRIM_RST;
		end else if (st_r == pfl_pkg::PFL_IDLE) begin
			osc_trim_code <= osc_trim_init;
		end else if (st_r == pfl_pkg::PFL_UPDATE) begin
			osc_trim_code <= trim_calc; // [R11] [R20]
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			fll_locked <= 1'b0;
		end else if (!run) begin
			fll_locked <= 1'b0; // [R23]
		end else if (st_r == pfl_pkg::PFL_UPDATE) begin
			fll_locked <= (err_mag <= `PFL_ERR_W'(tol_eff)); // [R16] [R18] [R23]
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			osc_band_out  <= '0;
			osc_power_out <= 1'b0;
			fll_busy      <= 1'b0;
		end else begin
			osc_band_out  <= osc_band_select; // [R9]
			osc_power_out <= osc_power_on;
			fll_busy      <= (st_nxt != pfl_pkg::PFL_IDLE);
		end
	end

endmodule

`default_nettype wire

// file: verilog/pfl_pkg.sv
`default_nettype none
package pfl_pkg;

	typedef enum logic [1:0] {
		PFL_IDLE    = 2'b00,
		PFL_MEASURE = 2'b01,
		PFL_UPDATE  = 2'b10,
		PFL_SETTLE  = 2'b11
	} pfl_fll_state_t;

endpackage

`default_nettype wire

// file: verilog/pfl_trim_calc.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfl_defines.svh"

module pfl_trim_calc (
	input  wire logic signed [`PFL_ERR_W-1:0]  err,
	input  wire logic        [`PFL_GAIN_W-1:0] igain,
	input  wire logic        [`PFL_GAIN_W-1:0] pgain,
	input  wire logic        [`PFL_TRIM_W-1:0] limit,
	input  wire logic        [`PFL_TRIM_W-1:0] trim,
	output logic             [`PFL_TRIM_W-1:0] trim_nxt
);

	// codes above the table are clamped to the largest gain
	function automatic logic signed [`PFL_SCALE_W-1:0] pfl_scale(
		input logic signed [`PFL_ERR_W-1:0]  e,
		input logic        [`PFL_GAIN_W-1:0] code
	);
		logic [`PFL_GAIN_W-1:0] c;
		c = (code > `PFL_GAIN_MAX) ? `PFL_GAIN_MAX : code;
		pfl_scale = `PFL_SCALE_W'(e) <<< c; // [R19]
	endfunction

	logic signed [`PFL_SCALE_W-1:0] sum;
	logic signed [`PFL_SCALE_W-1:0] delta;
	logic signed [`PFL_SCALE_W-1:0] lim_s;
	logic signed [`PFL_SCALE_W-1:0] bounded;
	logic signed [`PFL_SCALE_W-1:0] raw;

	always_comb begin
		sum   = pfl_scale(err, igain) + pfl_scale(err, pgain); // [R14]
		delta = sum >>> `PFL_GAIN_FRAC;
		lim_s = $signed({{(`PFL_SCALE_W-`PFL_TRIM_W){1'b0}}, limit});
		// adjustment magnitude capped by the step limit
		if (delta > lim_s) begin // [R15]
			bounded = lim_s;
		end else if (delta < -lim_s) begin
			bounded = -lim_s;
		end else begin
			bounded = delta;
		end
		raw = $signed({{(`PFL_SCALE_W-`PFL_TRIM_W){1'b0}}, trim}) + bounded; // [R14]
		// saturate instead of wrapping across band ends
		if (raw < 0) begin // [R22]
			trim_nxt = '0;
		end else if (raw > $signed({{(`PFL_SCALE_W-`PFL_TRIM_W){1'b0}}, `PFL_TRIM_MAX})) begin
			trim_nxt = `PFL_TRIM_MAX;
		end else begin
			trim_nxt = raw[`PFL_TRIM_W-1:0];
		end
	end

endmodule

`default_nettype wire
